//--- verilog/exec_pkg.sv
package exec_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_OPERAND = 8'h04;
  localparam logic [7:0] ADDR_ACC = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_PC = 8'h10;
  localparam logic [7:0] ADDR_STACK = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // command word fields
  localparam int OP_LSB = 0;
  localparam int OP_W = 5;
  localparam int BIT_LSB = 8;
  localparam int BIT_W = 3;
  localparam int IMM_LSB = 16;
  // flag register bits
  localparam int FLAG_C = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_EMI = 4;
  localparam int FLAG_W = 5;
  // status register bits
  localparam int STAT_SKIP = 0;
  localparam int STAT_IRQ = 1;
  // values
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ALL = 8'hFF;
  localparam int NIB = 4;
  typedef enum logic [4:0] {
    idle_instruction,
    disjunction_mem,
    disjunction_imm,
    disjunction_to_ram,
    pop_call_site,
    pop_with_value,
    interrupt_exit,
    rotate_left_in_place,
    rotate_left_to_accumulator,
    rotate_left_via_carry,
    rotate_left_via_carry_to_accumulator,
    rotate_right_in_place,
    rotate_right_to_accumulator,
    rotate_right_via_carry,
    rotate_right_via_carry_to_accumulator,
    subtract_with_borrow,
    subtract_with_borrow_to_ram,
    decrement_skip_if_zero,
    decrement_to_accumulator_skip_if_zero,
    set_all,
    set_bit
  } opcode_e;
  typedef enum logic {ph_ready, ph_dummy} phase_e;
endpackage

//--- verilog/core_exec.sv
// Contract
// - idle instruction only advances pc and clears the status bits
// - or with memory or immediate, Z only
// - return reloads pc from stack top
// - return with value also loads accumulator
// - interrupt exit pops pc, sets enable
// - pending interrupt served before main program
// - rotate left in place, no flags
// - rotate left into accumulator, no flags
// - nine bit left rotate through carry
// - carry left rotate into accumulator
// - rotate right in place, no flags
// - rotate right into accumulator, no flags
// - nine bit right rotate through carry
// - carry right rotate into accumulator
// - acc minus operand minus not carry
// - carry clear when negative, else set
// - borrow subtract result to memory
// - decrement memory, skip when zero
// - taken skip costs one dummy cycle
// - decrement into accumulator, skip when zero
// - set all writes FFH, no flags
// - bit set forces one bit only
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module core_exec #(
  parameter int PC_W = 10,
  parameter logic [9:0] IRQ_VECTOR = 10'h004
) (
  input wire logic pclk, // 100 MHz clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped
  input wire logic irq_pending, // interrupt request waiting
  output logic master_interrupt_enable // global interrupt enable
);
  logic [7:0] acc, next_acc;
  logic [7:0] operand, next_operand;
  localparam int FLAG_W_L = exec_pkg::FLAG_W;
  logic [FLAG_W_L-1:0] flags, next_flags;
  logic [PC_W-1:0] pc, next_pc;
  logic [PC_W-1:0] stack_top, next_stack_top;
  logic skip_taken, next_skip_taken;
  logic irq_taken, next_irq_taken;
  exec_pkg::phase_e phase, next_phase;
  logic [31:0] next_prdata;
  logic mapped, access, exec;
  exec_pkg::opcode_e op;
  logic [7:0] imm;
  logic [2:0] bit_sel;
  logic [8:0] diff;
  logic [4:0] ndiff;
  logic [7:0] dec;

  function automatic logic [7:0] rot_left(input logic [7:0] v,
                                          input logic in0);
    rot_left = {v[6:0], in0};
  endfunction

  function automatic logic [7:0] rot_right(input logic [7:0] v,
                                           input logic in7);
    rot_right = {in7, v[7:1]};
  endfunction

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == exec_pkg::BYTE_ZERO);
  endfunction

  always_comb begin
    unique case (paddr)
      exec_pkg::ADDR_CMD, exec_pkg::ADDR_OPERAND, exec_pkg::ADDR_ACC,
      exec_pkg::ADDR_FLAGS, exec_pkg::ADDR_PC, exec_pkg::ADDR_STACK,
      exec_pkg::ADDR_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign access = psel && penable;
  assign op = exec_pkg::opcode_e'(pwdata[exec_pkg::OP_LSB +: exec_pkg::OP_W]);
  assign imm = pwdata[exec_pkg::IMM_LSB +: 8];
  assign bit_sel = pwdata[exec_pkg::BIT_LSB +: exec_pkg::BIT_W];
  assign exec = access && pwrite && (paddr == exec_pkg::ADDR_CMD) &&
                (phase == exec_pkg::ph_ready);
  // subtract with the inverted carry as borrow in
  assign diff = {1'b0, acc} - {1'b0, operand} -
                {8'h00, ~flags[exec_pkg::FLAG_C]};
  assign ndiff = {1'b0, acc[exec_pkg::NIB-1:0]} -
                 {1'b0, operand[exec_pkg::NIB-1:0]} -
                 {4'h0, ~flags[exec_pkg::FLAG_C]};
  assign dec = operand - exec_pkg::BYTE_ONE;

  // the dummy phase stretches a taken skip to two cycles
  assign pready = (phase == exec_pkg::ph_dummy) ||
                  !(exec && ((op == exec_pkg::decrement_skip_if_zero) ||
                    (op == exec_pkg::decrement_to_accumulator_skip_if_zero))
                    && is_zero(dec));
  assign pslverr = access && !mapped;
  assign master_interrupt_enable = flags[exec_pkg::FLAG_EMI];

  always_comb begin
    next_acc = acc;
    next_operand = operand;
    next_flags = flags;
    next_pc = pc;
    next_stack_top = stack_top;
    next_skip_taken = skip_taken;
    next_irq_taken = irq_taken;
    next_phase = exec_pkg::ph_ready;
    if (exec) begin
      next_pc = pc + PC_W'(1);
      next_skip_taken = 1'b0;
      next_irq_taken = 1'b0;
      unique case (op)
        exec_pkg::disjunction_mem: begin
          next_acc = acc | operand;
          next_flags[exec_pkg::FLAG_Z] = is_zero(next_acc);
        end
        exec_pkg::disjunction_imm: begin
          next_acc = acc | imm;
          next_flags[exec_pkg::FLAG_Z] = is_zero(next_acc);
        end
        exec_pkg::disjunction_to_ram: begin
          next_operand = acc | operand;
          next_flags[exec_pkg::FLAG_Z] = is_zero(next_operand);
        end
        exec_pkg::pop_call_site: next_pc = stack_top;
        exec_pkg::pop_with_value: begin
          next_pc = stack_top;
          next_acc = imm;
        end
        exec_pkg::interrupt_exit: begin
          next_flags[exec_pkg::FLAG_EMI] = 1'b1;
          next_pc = stack_top;
          // a waiting request is taken at once; the popped address is
          // kept on the stack as the routine's return point
          if (irq_pending) begin
            next_pc = IRQ_VECTOR[PC_W-1:0];
            next_flags[exec_pkg::FLAG_EMI] = 1'b0;
            next_irq_taken = 1'b1;
          end
        end
        exec_pkg::rotate_left_in_place:
          next_operand = rot_left(operand, operand[7]);
        exec_pkg::rotate_left_to_accumulator:
          next_acc = rot_left(operand, operand[7]);
        exec_pkg::rotate_left_via_carry: begin
          next_operand = rot_left(operand, flags[exec_pkg::FLAG_C]);
          next_flags[exec_pkg::FLAG_C] = operand[7];
        end
        exec_pkg::rotate_left_via_carry_to_accumulator: begin
          next_acc = rot_left(operand, flags[exec_pkg::FLAG_C]);
          next_flags[exec_pkg::FLAG_C] = operand[7];
        end
        exec_pkg::rotate_right_in_place:
          next_operand = rot_right(operand, operand[0]);
        exec_pkg::rotate_right_to_accumulator:
          next_acc = rot_right(operand, operand[0]);
        exec_pkg::rotate_right_via_carry: begin
          next_operand = rot_right(operand, flags[exec_pkg::FLAG_C]);
          next_flags[exec_pkg::FLAG_C] = operand[0];
        end
        exec_pkg::rotate_right_via_carry_to_accumulator: begin
          next_acc = rot_right(operand, flags[exec_pkg::FLAG_C]);
          next_flags[exec_pkg::FLAG_C] = operand[0];
        end
        exec_pkg::subtract_with_borrow,
        exec_pkg::subtract_with_borrow_to_ram: begin
          if (op == exec_pkg::subtract_with_borrow)
            next_acc = diff[7:0];
          else
            next_operand = diff[7:0];
          next_flags[exec_pkg::FLAG_C] = ~diff[8];
          next_flags[exec_pkg::FLAG_AC] = ~ndiff[exec_pkg::NIB];
          next_flags[exec_pkg::FLAG_Z] = is_zero(diff[7:0]);
          next_flags[exec_pkg::FLAG_OV] = (acc[7] != operand[7]) &&
                                          (diff[7] != acc[7]);
        end
        exec_pkg::decrement_skip_if_zero,
        exec_pkg::decrement_to_accumulator_skip_if_zero: begin
          if (op == exec_pkg::decrement_skip_if_zero)
            next_operand = dec;
          else
            next_acc = dec;
          if (is_zero(dec)) begin
            next_pc = pc + PC_W'(2);
            next_skip_taken = 1'b1;
            next_phase = exec_pkg::ph_dummy;
          end
        end
        exec_pkg::set_all: next_operand = exec_pkg::BYTE_ALL;
        exec_pkg::set_bit:
          next_operand[bit_sel] = 1'b1;
        default: ; // idle and unused codes only advance the pc and clear the skip and irq status bits
      endcase
    end else if (access && pwrite && (phase == exec_pkg::ph_ready)) begin
      unique case (paddr)
        exec_pkg::ADDR_OPERAND: next_operand = pwdata[7:0];
        exec_pkg::ADDR_ACC: next_acc = pwdata[7:0];
        exec_pkg::ADDR_FLAGS: next_flags = pwdata[FLAG_W_L-1:0];
        exec_pkg::ADDR_PC: next_pc = pwdata[PC_W-1:0];
        exec_pkg::ADDR_STACK: next_stack_top = pwdata[PC_W-1:0];
        default: ;
      endcase
    end
  end

  // read data is latched in the setup cycle so it leaves a flip-flop
  always_comb begin
    next_prdata = prdata;
    if (psel && !penable) begin
      next_prdata = 32'h0000_0000;
      unique case (paddr)
        exec_pkg::ADDR_OPERAND: next_prdata[7:0] = operand;
        exec_pkg::ADDR_ACC: next_prdata[7:0] = acc;
        exec_pkg::ADDR_FLAGS: next_prdata[FLAG_W_L-1:0] = flags;
        exec_pkg::ADDR_PC: next_prdata[PC_W-1:0] = pc;
        exec_pkg::ADDR_STACK: next_prdata[PC_W-1:0] = stack_top;
        exec_pkg::ADDR_STATUS: begin
          next_prdata[exec_pkg::STAT_SKIP] = skip_taken;
          next_prdata[exec_pkg::STAT_IRQ] = irq_taken;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= 8'h00;
      operand <= 8'h00;
      flags <= '0;
      pc <= '0;
      stack_top <= '0;
      skip_taken <= 1'b0;
      irq_taken <= 1'b0;
      phase <= exec_pkg::ph_ready;
      prdata <= 32'h0000_0000;
    end else begin
      acc <= next_acc;
      operand <= next_operand;
      flags <= next_flags;
      pc <= next_pc;
      stack_top <= next_stack_top;
      skip_taken <= next_skip_taken;
      irq_taken <= next_irq_taken;
      phase <= next_phase;
      prdata <= next_prdata;
    end
  end

  idle_keeps_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::idle_instruction |=> acc == $past(acc) &&
    operand == $past(operand) && flags == $past(flags) &&
    pc == $past(pc) + PC_W'(1))
    else $error("idle instruction changed state");
  or_result_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::disjunction_mem |=>
    acc == ($past(acc) | $past(operand)) &&
    flags[exec_pkg::FLAG_Z] == (acc == 8'h00) &&
    flags[exec_pkg::FLAG_C] == $past(flags[exec_pkg::FLAG_C]))
    else $error("or result or flags wrong");
  ret_pc_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::pop_call_site |=>
    pc == $past(stack_top) && flags == $past(flags))
    else $error("return did not reload pc");
  ret_value_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::pop_with_value |=>
    acc == $past(imm) && pc == $past(stack_top))
    else $error("return with value wrong");
  interrupt_exit_enable_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::interrupt_exit && !irq_pending |=>
    master_interrupt_enable && pc == $past(stack_top))
    else $error("interrupt exit did not enable");
  interrupt_exit_pending_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::interrupt_exit && irq_pending |=>
    pc == IRQ_VECTOR[PC_W-1:0] && irq_taken)
    else $error("pending interrupt not served");
  rlc_carry_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::rotate_left_via_carry |=>
    operand == {$past(operand[6:0]), $past(flags[exec_pkg::FLAG_C])} &&
    flags[exec_pkg::FLAG_C] == $past(operand[7]))
    else $error("left carry rotate wrong");
  rotate_right_via_carry_to_accumulator_acc_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::rotate_right_via_carry_to_accumulator |=>
    acc == {$past(flags[exec_pkg::FLAG_C]), $past(operand[7:1])} &&
    operand == $past(operand))
    else $error("right carry rotate to acc wrong");
  sbc_carry_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::subtract_with_borrow && acc < operand |=>
    !flags[exec_pkg::FLAG_C])
    else $error("borrow not shown in carry");
  skip_dummy_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::decrement_skip_if_zero && operand == 8'h01 |->
    !pready ##1 pready && operand == 8'h00 && skip_taken)
    else $error("taken skip lacks dummy cycle");
  set_bit_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::set_bit |=>
    operand == ($past(operand) | (8'h01 << $past(bit_sel))) &&
    flags == $past(flags))
    else $error("bit set wrong");
  rl_place_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::rotate_left_in_place |=>
    operand == {$past(operand[6:0]), $past(operand[7])} &&
    acc == $past(acc) && flags == $past(flags))
    else $error("left rotate in place wrong");
  rla_acc_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::rotate_left_to_accumulator |=>
    acc == {$past(operand[6:0]), $past(operand[7])} &&
    operand == $past(operand) && flags == $past(flags))
    else $error("left rotate to acc wrong");
  rotate_left_via_carry_to_accumulator_acc_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::rotate_left_via_carry_to_accumulator |=>
    acc == {$past(operand[6:0]), $past(flags[exec_pkg::FLAG_C])} &&
    flags[exec_pkg::FLAG_C] == $past(operand[7]) && operand == $past(operand))
    else $error("left carry rotate to acc wrong");
  rr_place_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::rotate_right_in_place |=>
    operand == {$past(operand[0]), $past(operand[7:1])} &&
    acc == $past(acc) && flags == $past(flags))
    else $error("right rotate in place wrong");
  rra_acc_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::rotate_right_to_accumulator |=>
    acc == {$past(operand[0]), $past(operand[7:1])} &&
    operand == $past(operand) && flags == $past(flags))
    else $error("right rotate to acc wrong");
  rrc_carry_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::rotate_right_via_carry |=>
    operand == {$past(flags[exec_pkg::FLAG_C]), $past(operand[7:1])} &&
    flags[exec_pkg::FLAG_C] == $past(operand[0]))
    else $error("right carry rotate wrong");
  sbc_value_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::subtract_with_borrow |=>
    acc == 8'($past(acc) - $past(operand) -
    {7'h00, ~$past(flags[exec_pkg::FLAG_C])}) &&
    flags[exec_pkg::FLAG_Z] == (acc == 8'h00))
    else $error("borrow subtract result wrong");
  sbc_no_borrow_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::subtract_with_borrow && acc > operand |=>
    flags[exec_pkg::FLAG_C])
    else $error("no borrow but carry clear");
  subtract_with_borrow_to_ram_ram_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::subtract_with_borrow_to_ram |=>
    operand == 8'($past(acc) - $past(operand) -
    {7'h00, ~$past(flags[exec_pkg::FLAG_C])}) && acc == $past(acc))
    else $error("borrow subtract to memory wrong");
  sdz_plain_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::decrement_skip_if_zero && operand != 8'h01 |=>
    operand == $past(operand) - 8'h01 && pc == $past(pc) + PC_W'(1) &&
    flags == $past(flags))
    else $error("decrement without skip wrong");
  decrement_to_accumulator_skip_if_zero_acc_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::decrement_to_accumulator_skip_if_zero |=>
    acc == $past(operand) - 8'h01 && operand == $past(operand) &&
    flags == $past(flags))
    else $error("decrement to acc wrong");
  set_all_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && op == exec_pkg::set_all |=>
    operand == exec_pkg::BYTE_ALL && flags == $past(flags))
    else $error("set all wrong");
endmodule
`default_nettype wire

//--- tb/fetch_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module fetch_sequencer (
  input wire logic pclk, // bus clock
  output logic psel, // select
  output logic penable, // access phase
  output logic pwrite, // direction
  output logic [7:0] paddr, // byte address
  output logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  output logic irq_pending // request waiting
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    irq_pending = 1'b0;
  end
  task automatic set_irq(input logic v);
    irq_pending <= v;
  endtask
  // the extra edge at entry keeps a release and the next setup apart
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e,
    output int ws);
    logic r;
    ws = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // read right after the edge, these are the values that edge sampled
    do begin
      @(posedge pclk);
      r = pready;
      q = prdata;
      e = pslverr;
      if (r !== 1'b1) ws++;
    end while (r !== 1'b1 && ws < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

//--- tb/core_exec_logic_rotate_sub_skip_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module core_exec_logic_rotate_sub_skip_tb_top;
  localparam logic [9:0] VEC = 10'h2C0;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, mie, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int error_cnt = 0;
  int num_checks = 0;
  int ws;
  logic [16:0] sv [5] = '{{8'h50, 8'h20, 1'b1}, {8'h10, 8'h10, 1'b1},
    {8'h10, 8'h10, 1'b0}, {8'h80, 8'h01, 1'b1}, {8'h7F, 8'hFF, 1'b1}};
  always #5 pclk = ~pclk;
  core_exec #(.IRQ_VECTOR(VEC)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_pending(irq),
    .master_interrupt_enable(mie));
  fetch_sequencer seq (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_pending(irq));
  task automatic wrap_up();
    $display("errors %0d checks %0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    seq.xfer(w, a, d, q, e, ws);
    if (ws >= 20) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  task automatic see(string n, logic [7:0] a, logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(n, x, q);
  endtask
  task automatic ld(logic [7:0] a, m, logic [4:0] f, logic [9:0] p);
    bus(1'b1, exec_pkg::ADDR_ACC, {24'h0, a});
    bus(1'b1, exec_pkg::ADDR_OPERAND, {24'h0, m});
    bus(1'b1, exec_pkg::ADDR_FLAGS, {27'h0, f});
    bus(1'b1, exec_pkg::ADDR_PC, {22'h0, p});
  endtask
  task automatic ex(logic [4:0] op, logic [2:0] b, logic [7:0] i);
    bus(1'b1, exec_pkg::ADDR_CMD, {8'h00, i, 5'h00, b, 3'h0, op});
  endtask
  task automatic st(logic [7:0] a, m, logic [4:0] f, logic [9:0] p);
    see("acc", exec_pkg::ADDR_ACC, {24'h0, a});
    see("operand", exec_pkg::ADDR_OPERAND, {24'h0, m});
    see("flags", exec_pkg::ADDR_FLAGS, {27'h0, f});
    see("pc", exec_pkg::ADDR_PC, {22'h0, p});
  endtask
  task automatic t_misc();
    st(8'h00, 8'h00, 5'h00, 10'h000);
    bus(1'b0, 8'h1C, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    ld(8'h5A, 8'hC3, 5'h0F, 10'h3FF);
    ex(exec_pkg::idle_instruction, 3'h7, 8'hFF);
    st(8'h5A, 8'hC3, 5'h0F, 10'h000);
    // an unassigned code must behave as the idle instruction
    ex(5'h1F, 3'h0, 8'h00);
    st(8'h5A, 8'hC3, 5'h0F, 10'h001);
  endtask
  task automatic t_or();
    ld(8'h50, 8'h0A, 5'h0B, 10'h010);
    ex(exec_pkg::disjunction_mem, 3'h0, 8'h00);
    st(8'h5A, 8'h0A, 5'h0B, 10'h011);
    ld(8'h00, 8'hFF, 5'h0B, 10'h010);
    ex(exec_pkg::disjunction_imm, 3'h0, 8'h00);
    st(8'h00, 8'hFF, 5'h0F, 10'h011);
    ld(8'h81, 8'h18, 5'h04, 10'h010);
    ex(exec_pkg::disjunction_to_ram, 3'h0, 8'h00);
    st(8'h81, 8'h99, 5'h00, 10'h011);
  endtask
  task automatic t_ret();
    bus(1'b1, exec_pkg::ADDR_STACK, 32'h2A5);
    ld(8'h11, 8'h22, 5'h0F, 10'h010);
    ex(exec_pkg::pop_call_site, 3'h0, 8'h3C);
    st(8'h11, 8'h22, 5'h0F, 10'h2A5);
    ex(exec_pkg::pop_with_value, 3'h0, 8'h3C);
    st(8'h3C, 8'h22, 5'h0F, 10'h2A5);
    bus(1'b1, exec_pkg::ADDR_STACK, 32'h155);
    ld(8'h00, 8'h00, 5'h00, 10'h010);
    ex(exec_pkg::interrupt_exit, 3'h0, 8'h00);
    st(8'h00, 8'h00, 5'h10, 10'h155);
    chk("enable", 32'h1, {31'h0, mie});
    seq.set_irq(1'b1);
    ld(8'h00, 8'h00, 5'h00, 10'h010);
    ex(exec_pkg::interrupt_exit, 3'h0, 8'h00);
    st(8'h00, 8'h00, 5'h00, VEC);
    see("status", exec_pkg::ADDR_STATUS, 32'h2);
    seq.set_irq(1'b0);
  endtask
  task automatic t_rot();
    logic [7:0] m, r;
    logic c, nc;
    m = 8'h96;
    for (int op = 7; op <= 14; op++) begin
      for (int k = 0; k < 2; k++) begin
        c = k[0];
        nc = c;
        case (op)
          7, 8: r = {m[6:0], m[7]};
          9, 10: {nc, r} = {m, c};
          11, 12: r = {m[0], m[7:1]};
          default: {r, nc} = {c, m};
        endcase
        ld(8'h33, m, {4'hA, c}, 10'h020);
        ex(5'(op), 3'h0, 8'h00);
        if (op % 2 == 0)
          st(r, m, {4'hA, nc}, 10'h021);
        else
          st(8'h33, r, {4'hA, nc}, 10'h021);
      end
    end
  endtask
  task automatic t_sbc();
    logic [8:0] s;
    logic [4:0] lo, f;
    logic [7:0] a, m;
    logic c;
    for (int i = 0; i < 10; i++) begin
      {a, m, c} = sv[i / 2];
      s = {1'b0, a} - {1'b0, m} - 9'(!c);
      lo = {1'b0, a[3:0]} - {1'b0, m[3:0]} - 5'(!c);
      f = {1'b0, (a[7] != m[7]) && (s[7] != a[7]), s[7:0] == 8'h00,
        !lo[4], !s[8]};
      ld(a, m, {4'h0, c}, 10'h030);
      ex(i[0] ? exec_pkg::subtract_with_borrow_to_ram
        : exec_pkg::subtract_with_borrow, 3'h0, 8'h00);
      if (i[0]) st(a, s[7:0], f, 10'h031);
      else st(s[7:0], m, f, 10'h031);
    end
  endtask
  task automatic t_skip();
    logic [7:0] m, r;
    logic z;
    for (int i = 0; i < 4; i++) begin
      m = i[0] ? 8'h01 : (i < 2 ? 8'h00 : 8'h80);
      r = m - 8'h01;
      z = r == 8'h00;
      ld(8'h44, m, 5'h0B, 10'h040);
      ex(i < 2 ? exec_pkg::decrement_skip_if_zero
        : exec_pkg::decrement_to_accumulator_skip_if_zero, 3'h0, 8'h00);
      chk("waits", {31'h0, z}, ws);
      if (i < 2) st(8'h44, r, 5'h0B, 10'h041 + 10'(z));
      else st(r, m, 5'h0B, 10'h041 + 10'(z));
      see("status", exec_pkg::ADDR_STATUS, {31'h0, z});
    end
  endtask
  task automatic t_set();
    ld(8'h00, 8'h12, 5'h0F, 10'h050);
    ex(exec_pkg::set_all, 3'h0, 8'h00);
    st(8'h00, 8'hFF, 5'h0F, 10'h051);
    for (int b = 0; b < 8; b++) begin
      ld(8'h00, 8'h5A, 5'h0F, 10'h050);
      ex(exec_pkg::set_bit, 3'(b), 8'h00);
      st(8'h00, 8'h5A | (8'h01 << b), 5'h0F, 10'h051);
    end
    bus(1'b1, exec_pkg::ADDR_STATUS, 32'h3);
    see("status", exec_pkg::ADDR_STATUS, 32'h0);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_misc();
    t_or();
    t_ret();
    t_rot();
    t_sbc();
    t_skip();
    t_set();
    wrap_up();
  end
endmodule
`default_nettype wire
